// ===== hdl/sbp_boot_prog.sv
// Notes on behaviour
// RQ1: host opens with an all-ones sync byte; receiver runs at 1200 baud.
// RQ2: host sends the loader right after sync, with no gaps.
// RQ3: every loader byte received is echoed back on the transmit line.
// RQ4: after the last loader byte, execution starts with no host action.
// RQ5: loaded code drives port C bit 0 low, sets pointers, enters ROM routine.
// RQ6: control passes to the programming routine held in boot ROM.
// RQ7: receiver holds one finished byte while shifting in the next.
// RQ8: host sends the first data byte for the first location.
// RQ9: after programming a byte, read it back and transmit the value.
// RQ10: host compares each read-back with what it sent.
// RQ11: byte N+1 sits buffered and is programmed while host checks byte N.
// RQ12: host sends byte N+2 only after byte N is verified.
// RQ13: verify-and-queue repeats until host data runs out. The code stops after PROG_LEN bytes instead.
// RQ14: completion is shown on port C bit 0. The code flags it on o_done; port C bit 0 is already low from hand-off.
// RQ15: host supplies programming voltage on the high-voltage interrupt pin.
// RQ16: frames are 8 data bits, no parity, 1 stop bit at 1200 baud.
// RQ17: device sends one ready character before accepting data.
// RQ18: host logs every mismatch and keeps streaming.
`include "sbp_consts.svh"

module sbp_boot_prog
  import sbp_pkg::*;
#(
  parameter int BIT_CYC    = `SBP_CLK_HZ / `SBP_BAUD,
  parameter int LOADER_LEN = `SBP_LOADER_LEN,
  parameter int PROG_LEN   = `SBP_PROG_LEN
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  // serial link
  input  wire logic         i_rxd,
  output logic              o_txd,
  // programming voltage sense
  input  wire logic         i_hv_present,
  // nonvolatile array
  output sbp_mem_req_t      o_mem,
  input  wire sbp_mem_rsp_t i_mem,
  // status pins
  output logic              o_portc0,
  output logic              o_done,
  output logic              o_overrun
);

  localparam int CNT_W = $clog2(BIT_CYC + 1);
  localparam int LD_W  = $clog2(LOADER_LEN + 1);
  localparam int PG_W  = $clog2(PROG_LEN + 1);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_BIT = CNT_W'(BIT_CYC / 2);

  // parameters the logic cannot serve
  if (BIT_CYC < 4 || LOADER_LEN <= `SBP_DST_LO_IDX || PROG_LEN < 1 ||
      PROG_LEN > 65536) begin : g_bad_param
    $error("sbp_boot_prog: unsupported parameter value");
  end

  // true when a bit-period counter reaches the given limit
  function automatic logic at_count(input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] lim);
    return cnt == lim;
  endfunction

  // ---------------- receiver ----------------
  sbp_rx_st_t       rx_st_r,    rx_st_nxt;
  logic [CNT_W-1:0] rx_cnt_r,   rx_cnt_nxt;
  logic [3:0]       rx_bit_r,   rx_bit_nxt;
  logic [7:0]       rx_sh_r,    rx_sh_nxt;
  logic [7:0]       rx_buf_r,   rx_buf_nxt;
  logic             rx_vld_r,   rx_vld_nxt;
  logic             ovr_r,      ovr_nxt;
  logic             rx_take;

  // fixed-rate 8N1 receiver with a one-byte holding buffer
  always_comb begin
    rx_st_nxt  = rx_st_r;
    rx_cnt_nxt = rx_cnt_r + 1'b1;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt  = rx_sh_r;
    rx_buf_nxt = rx_buf_r;
    rx_vld_nxt = rx_vld_r & ~rx_take;
    ovr_nxt    = ovr_r;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_cnt_nxt = '0;
        if (!i_rxd) rx_st_nxt = RX_START;
      end
      RX_START: begin
        // recheck mid start bit so a glitch does not open a frame
        if (at_count(rx_cnt_r, HALF_BIT)) begin
          rx_cnt_nxt = '0;
          rx_bit_nxt = '0;
          rx_st_nxt  = i_rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (at_count(rx_cnt_r, BIT_LAST)) begin
          rx_cnt_nxt = '0;
          rx_sh_nxt  = {i_rxd, rx_sh_r[7:1]}; // RQ16
          rx_bit_nxt = rx_bit_r + 1'b1;
          if (rx_bit_r == `SBP_DATA_BITS - 1'b1) rx_st_nxt = RX_STOP;
        end
      end
      RX_STOP: begin
        if (at_count(rx_cnt_r, BIT_LAST)) begin
          rx_st_nxt = RX_IDLE;
          // a bad stop bit drops the frame
          if (i_rxd) begin
            // a full buffer not taken this cycle keeps its byte and flags overrun
            if (rx_vld_r && !rx_take) begin
              ovr_nxt = 1'b1;
            end else begin
              rx_buf_nxt = rx_sh_r; // RQ7
              rx_vld_nxt = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r  <= '0;
      rx_buf_r <= '0;
      rx_vld_r <= 1'b0;
      ovr_r    <= 1'b0;
    end else begin
      rx_st_r  <= rx_st_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r  <= rx_sh_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_vld_r <= rx_vld_nxt;
      ovr_r    <= ovr_nxt;
    end
  end

  // ---------------- transmitter ----------------
  logic [9:0]       tx_sh_r,   tx_sh_nxt;
  logic [3:0]       tx_left_r, tx_left_nxt;
  logic [CNT_W-1:0] tx_cnt_r,  tx_cnt_nxt;
  logic             txd_r,     txd_nxt;
  logic             tx_go;
  logic [7:0]       tx_data;
  logic             tx_idle;

  assign tx_idle = (tx_left_r == '0);

  // 10-bit frame shifter, lsb first, stop bit last
  always_comb begin
    tx_sh_nxt   = tx_sh_r;
    tx_left_nxt = tx_left_r;
    tx_cnt_nxt  = tx_cnt_r;
    txd_nxt     = txd_r;
    if (tx_idle) begin
      txd_nxt = `SBP_TXD_IDLE;
      if (tx_go) begin
        tx_sh_nxt   = {1'b1, tx_data, 1'b0}; // RQ16
        tx_left_nxt = `SBP_DATA_BITS + 4'h2;
        tx_cnt_nxt  = '0;
        txd_nxt     = 1'b0;
      end
    end else if (at_count(tx_cnt_r, BIT_LAST)) begin
      tx_cnt_nxt  = '0;
      tx_sh_nxt   = {1'b1, tx_sh_r[9:1]};
      tx_left_nxt = tx_left_r - 1'b1;
      txd_nxt     = (tx_left_r == 4'h1) ? `SBP_TXD_IDLE : tx_sh_r[1];
    end else begin
      tx_cnt_nxt = tx_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      tx_sh_r   <= '1;
      tx_left_r <= '0;
      tx_cnt_r  <= '0;
      txd_r     <= `SBP_TXD_IDLE;
    end else begin
      tx_sh_r   <= tx_sh_nxt;
      tx_left_r <= tx_left_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      txd_r     <= txd_nxt;
    end
  end

  // ---------------- boot and programming control ----------------
  logic [7:0]      ld_mem [LOADER_LEN];
  sbp_ctl_st_t     st_r,     st_nxt;
  logic [LD_W-1:0] ld_cnt_r, ld_cnt_nxt;
  logic [PG_W-1:0] src_r,    src_nxt;
  logic [15:0]     dst_r,    dst_nxt;
  sbp_mem_req_t    mem_r,    mem_nxt;
  logic [7:0]      rb_r,     rb_nxt;
  logic            pc0_r,    pc0_nxt;
  logic            done_r,   done_nxt;
  logic            ld_we;

  // sequencing of sync, loader, hand-off and the pipelined program loop
  always_comb begin
    st_nxt     = st_r;
    ld_cnt_nxt = ld_cnt_r;
    src_nxt    = src_r;
    dst_nxt    = dst_r;
    mem_nxt    = mem_r;
    rb_nxt     = rb_r;
    pc0_nxt    = pc0_r;
    done_nxt   = done_r;
    rx_take    = 1'b0;
    tx_go      = 1'b0;
    tx_data    = rb_r;
    ld_we      = 1'b0;
    unique case (st_r)
      CS_SYNC: begin
        // anything but the sync character is discarded
        if (rx_vld_r) begin
          rx_take = 1'b1;
          if (rx_buf_r == `SBP_SYNC_BYTE) st_nxt = CS_LOAD; // RQ1
        end
      end
      CS_LOAD: begin
        // wait for the shifter so no echo is ever lost
        if (rx_vld_r && tx_idle) begin
          rx_take    = 1'b1;
          ld_we      = 1'b1;
          tx_go      = 1'b1;
          tx_data    = rx_buf_r; // RQ3
          ld_cnt_nxt = ld_cnt_r + 1'b1;
          if (ld_cnt_r == LD_W'(LOADER_LEN - 1)) st_nxt = CS_EXEC; // RQ4
        end
      end
      CS_EXEC: begin
        pc0_nxt = 1'b0; // RQ5
        src_nxt = '0; // RQ5
        dst_nxt = {ld_mem[`SBP_DST_HI_IDX], ld_mem[`SBP_DST_LO_IDX]}; // RQ5
        st_nxt  = CS_READY; // RQ6
      end
      CS_READY: begin
        if (tx_idle) begin
          tx_go   = 1'b1;
          tx_data = `SBP_READY_CHAR; // RQ17
          st_nxt  = CS_WAIT;
        end
      end
      CS_WAIT: begin
        // no write is started without programming voltage
        if (rx_vld_r && i_hv_present) begin
          rx_take      = 1'b1;
          mem_nxt.wr   = 1'b1;
          mem_nxt.addr = dst_r;
          mem_nxt.data = rx_buf_r; // RQ11
          st_nxt       = CS_WRITE;
        end
      end
      CS_WRITE: begin
        if (i_mem.done) begin
          mem_nxt.wr = 1'b0;
          mem_nxt.rd = 1'b1; // RQ9
          st_nxt     = CS_READ;
        end
      end
      CS_READ: begin
        if (i_mem.done) begin
          mem_nxt.rd = 1'b0;
          rb_nxt     = i_mem.rdata;
          st_nxt     = CS_SEND;
        end
      end
      CS_SEND: begin
        if (tx_idle) begin
          tx_go   = 1'b1; // RQ9
          dst_nxt = dst_r + 16'h0001;
          src_nxt = src_r + 1'b1;
          // loop back for the next queued byte
          st_nxt  = (src_r == PG_W'(PROG_LEN - 1)) ? CS_DONE : CS_WAIT; // RQ13
        end
      end
      CS_DONE: begin
        done_nxt = 1'b1; // RQ14
        pc0_nxt  = 1'b0; // RQ14
      end
    endcase
  end

  // loader image store; only written while the loader streams in
  always_ff @(posedge i_core_clk) begin
    if (ld_we) ld_mem[ld_cnt_r] <= rx_buf_r;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      st_r     <= CS_SYNC;
      ld_cnt_r <= '0;
      src_r    <= '0;
      dst_r    <= '0;
      mem_r    <= '0;
      rb_r     <= '0;
      pc0_r    <= `SBP_PORTC0_RST;
      done_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      ld_cnt_r <= ld_cnt_nxt;
      src_r    <= src_nxt;
      dst_r    <= dst_nxt;
      mem_r    <= mem_nxt;
      rb_r     <= rb_nxt;
      pc0_r    <= pc0_nxt;
      done_r   <= done_nxt;
    end
  end

  // every output straight from a flip-flop
  assign o_txd     = txd_r;
  assign o_mem     = mem_r;
  assign o_portc0  = pc0_r;
  assign o_done    = done_r;
  assign o_overrun = ovr_r;

endmodule

// ===== hdl/sbp_consts.svh
`ifndef SBP_CONSTS_SVH
`define SBP_CONSTS_SVH

// link timing: 1200 baud, 8 data bits, no parity, 1 stop bit
`define SBP_CLK_HZ      100000000
`define SBP_BAUD        1200
`define SBP_DATA_BITS   4'h8
// characters of the boot exchange
`define SBP_SYNC_BYTE   8'hFF
`define SBP_READY_CHAR  8'hFF
// loader image size and where it holds the destination pointer
`define SBP_LOADER_LEN  25
`define SBP_DST_HI_IDX  1
`define SBP_DST_LO_IDX  2
// bytes programmed before completion is flagged
`define SBP_PROG_LEN    8192
// reset levels of the pins
`define SBP_TXD_IDLE    1'b1
`define SBP_PORTC0_RST  1'b1

`endif

// ===== hdl/sbp_pkg.sv
package sbp_pkg;

  // request to the nonvolatile array, held until acknowledged
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } sbp_mem_req_t;

  // answer from the nonvolatile array
  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } sbp_mem_rsp_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } sbp_rx_st_t;

  typedef enum logic [3:0] {
    CS_SYNC,
    CS_LOAD,
    CS_EXEC,
    CS_READY,
    CS_WAIT,
    CS_WRITE,
    CS_READ,
    CS_SEND,
    CS_DONE
  } sbp_ctl_st_t;

endpackage

// ===== tb/sbp_boot_prog_chk_sva.sv
module sbp_boot_prog_chk
  import sbp_pkg::*;
(
  // clock and reset
  input wire logic         i_core_clk,
  input wire logic         i_resetn,
  // watched ports
  input wire logic         o_txd,
  input wire logic         i_hv_present,
  input wire sbp_mem_req_t o_mem,
  input wire sbp_mem_rsp_t i_mem,
  input wire logic         o_portc0,
  input wire logic         o_done,
  input wire logic         o_overrun
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // write and read-back handshakes as steps
  sequence s_wr_ack;
    o_mem.wr && i_mem.done;
  endsequence
  sequence s_rd_ack;
    o_mem.rd && i_mem.done;
  endsequence
  sequence s_rd_phase;
    !o_mem.wr && o_mem.rd;
  endsequence

  chk_wr_then_rd: assert property (s_wr_ack |=> s_rd_phase)
    else $error("no read-back after write");
  chk_rd_release: assert property (s_rd_ack |=> !o_mem.rd && !o_mem.wr)
    else $error("read-back not released");
  chk_req_hold: assert property (o_mem.wr && !i_mem.done
    |=> o_mem.wr && $stable(o_mem.addr) && $stable(o_mem.data))
    else $error("write request dropped early");
  chk_one_op: assert property (!(o_mem.wr && o_mem.rd))
    else $error("write and read together");
  chk_hv_write: assert property ($rose(o_mem.wr) |-> $past(i_hv_present))
    else $error("write without voltage");
  chk_start_bit: assert property ($fell(o_txd) |-> !o_txd [*8])
    else $error("start bit too short");
  chk_portc0_low: assert property (!o_portc0 |=> !o_portc0)
    else $error("port bit left low state");
  chk_done_hold: assert property (o_done |=> o_done && !o_mem.wr)
    else $error("activity after completion");
  chk_reset_vals: assert property ($rose(i_resetn)
    |-> o_txd && o_portc0 && !o_done && !o_overrun)
    else $error("bad levels after reset");
endmodule

bind sbp_boot_prog sbp_boot_prog_chk sbp_boot_prog_chk_i (
  .i_core_clk  (i_core_clk),
  .i_resetn    (i_resetn),
  .o_txd       (o_txd),
  .i_hv_present(i_hv_present),
  .o_mem       (o_mem),
  .i_mem       (i_mem),
  .o_portc0    (o_portc0),
  .o_done      (o_done),
  .o_overrun   (o_overrun)
);

// ===== tb/sbp_host.sv
// host end of the serial link; line idles high between frames
module sbp_host #(
  parameter int BIT_CYC = 16
) (
  input  wire logic i_core_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_rxd = 1'b1;

  // one frame: start, eight bits lsb first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      repeat (BIT_CYC) @(posedge i_core_clk);
      #1;
    end
  endtask

  // bounded wait for a start bit, then mid-bit sampling
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (i_txd !== 1'b0 && n < 64 * BIT_CYC) begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 64 * BIT_CYC) return;
    repeat (BIT_CYC / 2) @(posedge i_core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_core_clk);
      b[i] = i_txd;
    end
    repeat (BIT_CYC) @(posedge i_core_clk);
    ok = (i_txd === 1'b1);
    // hand back off the edge so the caller drives nothing on it
    #1;
  endtask
endmodule

// ===== tb/tb.sv
module tb;
  import sbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BIT = 16;
  logic         i_core_clk, i_resetn, i_rxd, o_txd, i_hv_present;
  logic         o_portc0, o_done, o_overrun;
  sbp_mem_req_t mreq, q;
  sbp_mem_rsp_t mrsp = '0;
  logic [7:0]   ld [3] = '{8'h12, 8'hD0, 8'h00};
  logic [7:0]   dat [4] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0};
  logic [7:0]   mem [4];
  int           n_fail, n_tests, mcnt, wn;

  sbp_boot_prog #(.BIT_CYC(BIT), .LOADER_LEN(3), .PROG_LEN(4))
    sbp_boot_prog_i (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_rxd       (i_rxd),
    .o_txd       (o_txd),
    .i_hv_present(i_hv_present),
    .o_mem       (mreq),
    .i_mem       (mrsp),
    .o_portc0    (o_portc0),
    .o_done      (o_done),
    .o_overrun   (o_overrun)
  );
  sbp_host #(.BIT_CYC(BIT)) sbp_host_i (
    .i_core_clk(i_core_clk),
    .i_txd     (o_txd),
    .o_rxd     (i_rxd)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one frame from the device, a lost frame ends the run
  task automatic get(input logic [7:0] exp);
    logic [7:0] b;
    logic       ok;
    sbp_host_i.recv(b, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t device frame lost", $time);
      stop_test();
    end else begin
      chk({8'h00, b}, {8'h00, exp});
    end
  endtask

  // array model: slow ack, read data scrambled when not valid
  always @(posedge i_core_clk) begin
    q = mreq;
    #1;
    mrsp.done = 1'b0;
    mrsp.rdata = ~mrsp.rdata;
    if (q.wr | q.rd) mcnt++;
    if (mcnt == 3) begin
      mcnt = 0;
      mrsp.done = 1'b1;
      if (q.wr) begin
        chk(q.addr, 16'hD000 + 16'(wn));
        mem[q.addr[1:0]] = q.data;
        wn++;
      end else
        mrsp.rdata = mem[q.addr[1:0]];
    end
  end

  // boot phase: stray byte, sync, loader echoes, ready character
  task automatic t_boot();
    chk(o_portc0, 1);
    // a stray byte before sync must draw no echo
    sbp_host_i.send(8'h55);
    fork
      begin
        sbp_host_i.send(8'hFF);
        for (int i = 0; i < 3; i++) sbp_host_i.send(ld[i]);
      end
      begin
        for (int i = 0; i < 3; i++) get(ld[i]);
        get(8'hFF);
      end
    join
    chk(o_portc0, 0);
  endtask

  // pipelined programming; the first byte waits for the voltage
  task automatic t_program();
    sbp_host_i.send(dat[0]);
    repeat (20) @(posedge i_core_clk);
    chk(mreq.wr, 0);
    #1 i_hv_present = 1'b1;
    // keep exactly one byte queued; mismatches do not stop the stream
    for (int n = 0; n < 4; n++) begin
      fork
        if (n < 3) sbp_host_i.send(dat[n + 1]);
        get(dat[n]);
      join
    end
    for (int i = 0; i < 64 && o_done !== 1'b1; i++) @(posedge i_core_clk);
    chk(o_done, 1);
    chk(o_overrun, 0);
    chk(16'(wn), 4);
  endtask

  // after completion bytes stay unconsumed, so a second one overruns
  task automatic t_overrun();
    sbp_host_i.send(8'h11);
    chk(o_overrun, 0);
    sbp_host_i.send(8'h22);
    chk(o_overrun, 1);
    chk(o_done, 1);
  endtask

  initial begin
    i_resetn = 1'b0;
    i_hv_present = 1'b0;
    repeat (8) @(posedge i_core_clk);
    #1 i_resetn = 1'b1;
    t_boot();
    t_program();
    t_overrun();
    stop_test();
  end
endmodule
